// ===== core/fault_diag_pkg.sv
// types shared by the fault manager and its retry counters
package fault_diag_pkg;

    typedef struct packed {
        logic vpwr_ov;
        logic vpwr_uv;
        logic vdd_fail;
        logic supply_por;
        logic temp_warn;
        logic wake_reset_input;
        logic [3:0] overcurrent;
        logic [3:0] overtemp;
        logic [3:0] severe_short;
        logic [3:0] short_to_supply;
        logic [3:0] open_load_off;
        logic [3:0] open_load_on;
        logic [3:0] gate_off;
    } pin_s;

    typedef struct packed {
        logic [3:0] severe_short_flag;
        logic [3:0] overcurrent_flag;
        logic [3:0] overtemp_flag;
        logic [3:0] short_to_supply_flag;
        logic [3:0] open_load_off_flag;
        logic [3:0] open_load_on_flag;
        logic overvoltage_flag;
        logic undervoltage_flag;
        logic temp_prewarning_flag;
    } status_s;

    typedef struct packed {
        logic sense_output_enable;
        logic temp_feedback_select;
        logic [1:0] channel;
        logic sense_ratio_select;
        logic recopy_active;
    } sense_s;

    typedef enum logic [2:0] {
        RETRY_IDLE = 3'b001,
        RETRY_WAIT = 3'b010,
        RETRY_SPENT = 3'b100
    } retry_state_e;

endpackage

// ===== core/fault_diag_regs.svh
// timing counts, limits and reset values for the fault manager
`ifndef FAULT_DIAG_REGS_SVH
`define FAULT_DIAG_REGS_SVH

`define CLK_MHZ 10
`define RETRY_PERIOD_US 150
`define RETRY_CYC (`RETRY_PERIOD_US * `CLK_MHZ)
`define RETRY_TIMER_W 11
`define RETRY_MAX 5'h10
`define LED_CHECK_US 100
`define LED_CHECK_CYC (`LED_CHECK_US * `CLK_MHZ)
`define LED_TIMER_W 10
`define DUTY_FULL 7'h7f
`define FLAGS_RESET 4'h0

`endif

// ===== core/quad_switch_fault_diag_manager.sv
// fault latching, status flags, fault pin and auto-retry for four outputs
// Function
// - severe short flag clears after status read
// - over-voltage with protection forces outputs off
// - over-voltage sets flag, read clears it
// - protection disabled: warn only, clear when gone and read
// - fail-safe: wake reset input enables protection
// - under-voltage: outputs off, fault pin, flag
// - recovery with outputs off releases pin
// - recovery with output on keeps latch
// - supply failure resets latches, severe short, overcurrent, overtemp, voltage flags
// - retry request from overcurrent, overtemp, undervoltage
// - retry each period, at most sixteen
// - mode transitions reset retry counters
// - retry restores inrush current profile in the re-enable cycle
// - short to supply latches two flags
// - short detection disable, flag held till read
// - off open load clears on read
// - off open load detection disable
// - on open load flags without shutdown
// - led check at full duty per period
// - on open load clears when gone and read
// - sense routing, recopy only on, not fail-safe
// - prewarning latched in normal mode only
// - status held until first valid read
`timescale 1ns/1ps
`include "fault_diag_regs.svh"

module quad_switch_fault_diag_manager (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire fault_diag_pkg::pin_s i_pins,
    input wire logic [3:0] i_cmd_on,
    input wire logic [3:0][6:0] i_duty,
    input wire logic i_fail_safe,
    input wire logic i_retry_enable,
    input wire logic i_overvoltage_protect_disable,
    input wire logic [3:0] i_short_to_supply_disable,
    input wire logic [3:0] i_open_load_off_disable,
    input wire logic [3:0] i_open_load_on_disable,
    input wire logic [3:0] i_led_open_load_select,
    input wire fault_diag_pkg::sense_s i_sense_cfg,
    input wire logic i_status_read,
    output logic [3:0] o_high_side_output,
    output logic o_fault_flag_n,
    output fault_diag_pkg::status_s o_status,
    output logic [3:0] o_inrush_restore,
    output fault_diag_pkg::sense_s o_analog_sense_output
);
    logic [1:0] rst_sync_reg, rst_sync_next;
    logic rst_n;
    fault_diag_pkg::pin_s pin1_reg, pin1_next, pin_reg, pin_next;
    fault_diag_pkg::status_s flag_reg, flag_next, set;
    fault_diag_pkg::sense_s sense_reg, sense_next;
    logic [3:0] latch_rt_reg, latch_rt_next, latch_sc_reg, latch_sc_next;
    logic [3:0] cmd_prev_reg, hs_reg, hs_next, inrush_reg, inrush_next;
    logic fs_prev_reg, fault_n_reg, fault_n_next;
    logic ov_prot, ov_shut, clear_all, mode_change, fault_any;
    logic [3:0] cmd_rise, rt_trip, rt_gone, os_cond, oloff_cond, olon_cond;
    logic [3:0] retry_pulse, retry_req, led_tick;

    // release of reset passes two flops; assertion stays asynchronous
    assign rst_sync_next = {rst_sync_reg[0], 1'b1};
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rst_sync_reg <= 2'h0;
        else if (i_ce)
            rst_sync_reg <= rst_sync_next;
    end
    assign rst_n = rst_sync_reg[1];

    // comparator pins are asynchronous; only pin_reg is read below
    always_comb
    begin
        pin1_next = i_pins;
        pin_next = pin1_reg;
    end
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin1_reg <= '0;
            pin_reg <= '0;
        end
        else if (i_ce)
        begin
            pin1_reg <= pin1_next;
            pin_reg <= pin_next;
        end
    end

    assign ov_prot = i_fail_safe ? pin_reg.wake_reset_input
                                 : !i_overvoltage_protect_disable;
    // comparator already applies the hysteresis on release
    assign ov_shut = pin_reg.vpwr_ov && ov_prot;
    assign clear_all = pin_reg.vdd_fail || pin_reg.supply_por;
    assign mode_change = i_fail_safe ^ fs_prev_reg;
    assign cmd_rise = i_cmd_on & ~cmd_prev_reg;

    // off-state checks only once the gate is really off
    assign os_cond = pin_reg.short_to_supply & ~i_short_to_supply_disable
                     & ~i_cmd_on & pin_reg.gate_off;
    assign oloff_cond = pin_reg.open_load_off & ~i_open_load_off_disable
                        & ~i_cmd_on & pin_reg.gate_off;

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++)
        begin : g_chan
            logic [`LED_TIMER_W-1:0] led_cnt_reg, led_cnt_next;
            logic led_run;

            // led loads need a whole period fully on before a check counts
            assign led_run = hs_reg[ch] && (i_duty[ch] == `DUTY_FULL);
            always_comb
            begin
                led_cnt_next = '0;
                if (led_run && led_cnt_reg != `LED_TIMER_W'(`LED_CHECK_CYC - 1))
                    led_cnt_next = led_cnt_reg + `LED_TIMER_W'(1);
            end
            always_ff @(posedge i_clk or negedge rst_n)
            begin
                if (!rst_n)
                    led_cnt_reg <= '0;
                else if (i_ce)
                    led_cnt_reg <= led_cnt_next;
            end
            assign led_tick[ch] = led_run
                && led_cnt_reg == `LED_TIMER_W'(`LED_CHECK_CYC - 1);
            assign olon_cond[ch] = pin_reg.open_load_on[ch] && hs_reg[ch]
                && !i_open_load_on_disable[ch]
                && (!i_led_open_load_select[ch] || led_tick[ch]);

            assign retry_req[ch] = latch_rt_reg[ch] && (flag_reg.overcurrent_flag[ch]
                || flag_reg.overtemp_flag[ch] || flag_reg.undervoltage_flag);

            retry_channel u_retry (
                .i_clk(i_clk),
                .i_rst_n(rst_n),
                .i_ce(i_ce),
                .i_request(retry_req[ch]),
                .i_enable(i_retry_enable),
                .i_count_clear(mode_change || clear_all),
                .o_retry(retry_pulse[ch]),
                .o_count()
            );
        end
    endgenerate

    // latched shutdown; severe short never delatches by retry
    assign rt_trip = pin_reg.overcurrent | (pin_reg.overtemp & i_cmd_on)
                     | ({4{pin_reg.vpwr_uv}} & i_cmd_on);
    assign rt_gone = ~pin_reg.overcurrent & ~pin_reg.overtemp & {4{!pin_reg.vpwr_uv}};
    always_comb
    begin
        latch_rt_next = rt_trip | (latch_rt_reg
            & ~(rt_gone & (cmd_rise | retry_pulse)));
        latch_sc_next = pin_reg.severe_short | (latch_sc_reg
            & ~(~pin_reg.severe_short & cmd_rise));
        inrush_next = retry_pulse & latch_rt_reg & rt_gone;
        if (clear_all || mode_change)
        begin
            latch_rt_next = '0;
            latch_sc_next = '0;
        end
        hs_next = i_cmd_on & ~latch_rt_next & ~latch_sc_next
                  & ~{4{ov_shut || pin_reg.vpwr_uv}};
    end

    // hardware sets win over the clearing read
    always_comb
    begin
        set = '0;
        set.severe_short_flag = pin_reg.severe_short;
        set.overcurrent_flag = pin_reg.overcurrent;
        set.overtemp_flag = pin_reg.overtemp;
        set.short_to_supply_flag = os_cond;
        set.open_load_off_flag = os_cond | oloff_cond;
        set.open_load_on_flag = olon_cond;
        set.overvoltage_flag = pin_reg.vpwr_ov;
        set.undervoltage_flag = pin_reg.vpwr_uv;
        set.temp_prewarning_flag = pin_reg.temp_warn && !i_fail_safe;
        flag_next = set | (flag_reg & ~{$bits(flag_reg){i_status_read}});
        if (clear_all)
        begin
            flag_next.severe_short_flag = `FLAGS_RESET;
            flag_next.overcurrent_flag = `FLAGS_RESET;
            flag_next.overtemp_flag = `FLAGS_RESET;
            flag_next.overvoltage_flag = 1'b0;
            flag_next.undervoltage_flag = 1'b0;
        end
    end

    // on-state open load and prewarning never pull the pin
    assign fault_any = (|latch_rt_reg) || (|latch_sc_reg) || ov_shut
        || pin_reg.vpwr_uv || (|(pin_reg.overtemp & ~i_cmd_on))
        || (|os_cond) || (|oloff_cond);
    assign fault_n_next = !fault_any;

    always_comb
    begin
        sense_next = i_sense_cfg;
        sense_next.recopy_active = i_sense_cfg.sense_output_enable
            && !i_sense_cfg.temp_feedback_select && !i_fail_safe
            && hs_reg[i_sense_cfg.channel];
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_reg <= '0;
            latch_rt_reg <= '0;
            latch_sc_reg <= '0;
            cmd_prev_reg <= '0;
            hs_reg <= '0;
            inrush_reg <= '0;
            fs_prev_reg <= 1'b0;
            fault_n_reg <= 1'b1;
            sense_reg <= '0;
        end
        else if (i_ce)
        begin
            flag_reg <= flag_next;
            latch_rt_reg <= latch_rt_next;
            latch_sc_reg <= latch_sc_next;
            cmd_prev_reg <= i_cmd_on;
            hs_reg <= hs_next;
            inrush_reg <= inrush_next;
            fs_prev_reg <= i_fail_safe;
            fault_n_reg <= fault_n_next;
            sense_reg <= sense_next;
        end
    end

    assign o_high_side_output = hs_reg;
    assign o_fault_flag_n = fault_n_reg;
    assign o_status = flag_reg;
    assign o_inrush_restore = inrush_reg;
    assign o_analog_sense_output = sense_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n || !i_ce);

    ov_shutdown_a: assert property (ov_shut |=> hs_reg == 4'h0 && !fault_n_reg)
        else $error("outputs on during over-voltage");
    ov_flag_set_a: assert property (pin_reg.vpwr_ov && !clear_all
        |=> flag_reg.overvoltage_flag)
        else $error("over-voltage flag missing");
    ov_warn_keep_a: assert property (pin_reg.vpwr_ov && i_status_read && !clear_all
        |=> flag_reg.overvoltage_flag)
        else $error("over-voltage warning lost");
    uv_off_a: assert property (pin_reg.vpwr_uv && !clear_all
        |=> hs_reg == 4'h0 && flag_reg.undervoltage_flag && !fault_n_reg)
        else $error("under-voltage not handled");
    sc_read_clear_a: assert property (i_status_read && pin_reg.severe_short == 4'h0
        |=> flag_reg.severe_short_flag == 4'h0)
        else $error("severe short flag not cleared");
    // any output, so the channels the bench shorts are watched too
    os_latch_a: assert property (|os_cond |=> !fault_n_reg
        && ((flag_reg.short_to_supply_flag & flag_reg.open_load_off_flag & $past(os_cond))
        == $past(os_cond)))
        else $error("short to supply not latched");
    prewarn_fs_a: assert property (i_fail_safe && !flag_reg.temp_prewarning_flag
        |=> !flag_reg.temp_prewarning_flag)
        else $error("prewarning set in fail-safe");
    latch_pin_a: assert property (|latch_sc_reg |=> !fault_n_reg)
        else $error("fault pin high while latched");
    supply_reset_a: assert property (clear_all |=> latch_rt_reg == 4'h0
        && flag_reg.overcurrent_flag == 4'h0)
        else $error("latched faults survive supply failure");
    recopy_fs_a: assert property (i_fail_safe |=> !sense_reg.recopy_active)
        else $error("recopy active in fail-safe");

    retry_seen_c: cover property (|inrush_reg);
    ov_trip_c: cover property (ov_shut ##1 !ov_shut);
    olon_led_c: cover property (|(olon_cond & i_led_open_load_select));
    read_clear_c: cover property (flag_reg.undervoltage_flag && i_status_read
        ##1 !flag_reg.undervoltage_flag);

endmodule // quad_switch_fault_diag_manager

// ===== core/retry_channel.sv
// per-output auto-retry timer and occurrence counter
`timescale 1ns/1ps
`include "fault_diag_regs.svh"

module retry_channel (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_request,
    input wire logic i_enable,
    input wire logic i_count_clear,
    output logic o_retry,
    output logic [4:0] o_count
);
    fault_diag_pkg::retry_state_e state_reg, state_next;
    logic [`RETRY_TIMER_W-1:0] timer_reg, timer_next;
    logic [4:0] count_reg, count_next;
    logic retry_reg, retry_next;

    always_comb
    begin
        state_next = state_reg;
        timer_next = timer_reg;
        count_next = count_reg;
        retry_next = 1'b0;
        if (i_count_clear)
        begin
            state_next = fault_diag_pkg::RETRY_IDLE;
            timer_next = '0;
            count_next = '0;
        end
        else
        begin
            case (state_reg)
                fault_diag_pkg::RETRY_IDLE:
                begin
                    timer_next = '0;
                    if (count_reg == `RETRY_MAX)
                        state_next = fault_diag_pkg::RETRY_SPENT;
                    else if (i_request && i_enable)
                        state_next = fault_diag_pkg::RETRY_WAIT;
                end
                fault_diag_pkg::RETRY_WAIT:
                begin
                    if (!i_request || !i_enable)
                        state_next = fault_diag_pkg::RETRY_IDLE;
                    else if (timer_reg == `RETRY_TIMER_W'(`RETRY_CYC - 1))
                    begin
                        retry_next = 1'b1;
                        count_next = count_reg + 5'h01;
                        state_next = fault_diag_pkg::RETRY_IDLE;
                    end
                    else
                        timer_next = timer_reg + `RETRY_TIMER_W'(1);
                end
                fault_diag_pkg::RETRY_SPENT:
                    state_next = fault_diag_pkg::RETRY_SPENT;
                default:
                    state_next = fault_diag_pkg::RETRY_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= fault_diag_pkg::RETRY_IDLE;
            timer_reg <= '0;
            count_reg <= '0;
            retry_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            count_reg <= count_next;
            retry_reg <= retry_next;
        end
    end

    assign o_retry = retry_reg;
    assign o_count = count_reg;

    retry_bound_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        count_reg <= `RETRY_MAX) else $error("retry count above limit");
    retry_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_count_clear && i_ce |=> count_reg == 5'h00) else $error("count not cleared");

endmodule // retry_channel

// ===== testbench/load_model.sv
// far side model: supply, temperature and load comparators seen by the fault manager
`timescale 1ns/1ps

module load_model (
    input wire logic [3:0] i_high_side_output,
    input wire fault_diag_pkg::pin_s i_inject,
    output fault_diag_pkg::pin_s o_pins
);
    always_comb
    begin
        o_pins = i_inject;
        // gate follows the output at once; a slow gate discharge is not modelled
        o_pins.gate_off = ~i_high_side_output;
        // off-state comparators can only see the output while the gate is off
        o_pins.short_to_supply = i_inject.short_to_supply & ~i_high_side_output;
        o_pins.open_load_off = i_inject.open_load_off & ~i_high_side_output;
        // load current is only measurable while conducting
        o_pins.open_load_on = i_inject.open_load_on & i_high_side_output;
    end
endmodule // load_model

// ===== testbench/tb_quad_switch_fault_diag_manager.sv
// self-checking bench for the four-output fault manager
`timescale 1ns/1ps

module tb_quad_switch_fault_diag_manager;
    logic clk, rst_n, fs, retry_en, overvoltage_protect_disable, rd, fault_n;
    logic [3:0] cmd, short_to_supply_disable, open_load_off_disable, open_load_on_disable, led_sel, hs, inrush;
    logic [3:0][6:0] duty;
    fault_diag_pkg::pin_s inj, pins;
    fault_diag_pkg::sense_s cfg, sense;
    fault_diag_pkg::status_s st;
    int miscompares, tests_run;

    load_model far_side (
        .i_high_side_output(hs),
        .i_inject(inj),
        .o_pins(pins)
    );

    quad_switch_fault_diag_manager uut (
        .i_clk(clk),
        .i_rst_n(rst_n),
        .i_ce(1'b1),
        .i_pins(pins),
        .i_cmd_on(cmd),
        .i_duty(duty),
        .i_fail_safe(fs),
        .i_retry_enable(retry_en),
        .i_overvoltage_protect_disable(overvoltage_protect_disable),
        .i_short_to_supply_disable(short_to_supply_disable),
        .i_open_load_off_disable(open_load_off_disable),
        .i_open_load_on_disable(open_load_on_disable),
        .i_led_open_load_select(led_sel),
        .i_sense_cfg(cfg),
        .i_status_read(rd),
        .o_high_side_output(hs),
        .o_fault_flag_n(fault_n),
        .o_status(st),
        .o_inrush_restore(inrush),
        .o_analog_sense_output(sense)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        if (miscompares == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one-cycle pulse stands for a completed serial status read
    task automatic rd_st;
        rd = 1'b1;
        w(1);
        rd = 1'b0;
    endtask

    task automatic short0;
        inj.severe_short[0] = 1'b1;
        w(4);
        inj.severe_short[0] = 1'b0;
        w(4);
    endtask

    // brief overcurrent on output 3, then time the automatic re-enable
    task automatic oc_retry(input logic ok);
        int n;
        logic pulse;
        n = 0;
        pulse = 1'b0;
        inj.overcurrent[3] = 1'b1;
        w(2);
        inj.overcurrent[3] = 1'b0;
        w(4);
        chk(hs[3], 1'b0);
        while (hs[3] !== 1'b1 && n < 1700)
        begin
            w(1);
            n++;
            if (inrush[3] === 1'b1)
                pulse = 1'b1;
        end
        w(1);
        if (inrush[3] === 1'b1)
            pulse = 1'b1;
        chk({hs[3], pulse, n > 1484 && n < 1516}, {ok, ok, ok});
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // generous span: about 29k cycles of tests
    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        test_done();
    end

    initial
    begin
        rst_n = 1'b0;
        inj = '0;
        cmd = 4'h0;
        duty = {4{7'h40}};
        fs = 1'b0;
        retry_en = 1'b0;
        overvoltage_protect_disable = 1'b0;
        short_to_supply_disable = 4'h0;
        open_load_off_disable = 4'h0;
        open_load_on_disable = 4'h0;
        led_sel = 4'h0;
        cfg = 6'b101110;
        rd = 1'b0;
        miscompares = 0;
        tests_run = 0;
        w(4);
        rst_n = 1'b1;
        w(6);
        chk({hs, fault_n, st}, {4'h0, 1'b1, 27'h0});
        cmd = 4'hf;
        w(4);
        chk({hs, sense}, 10'h3ef);
        inj.vpwr_ov = 1'b1;
        w(4);
        chk({hs, fault_n, st.overvoltage_flag}, 6'h01);
        inj.vpwr_ov = 1'b0;
        w(4);
        chk(hs, 4'hf);
        rd_st();
        chk({fault_n, st.overvoltage_flag}, 2'b10);
        overvoltage_protect_disable = 1'b1;
        inj.vpwr_ov = 1'b1;
        w(4);
        chk({hs, st.overvoltage_flag}, 5'h1f);
        rd_st();
        chk(st.overvoltage_flag, 1'b1);
        inj.vpwr_ov = 1'b0;
        w(4);
        rd_st();
        chk(st.overvoltage_flag, 1'b0);
        overvoltage_protect_disable = 1'b0;
        fs = 1'b1;
        inj.vpwr_ov = 1'b1;
        inj.temp_warn = 1'b1;
        w(4);
        chk({hs, sense, st.temp_prewarning_flag}, 11'h7dc);
        inj.wake_reset_input = 1'b1;
        w(4);
        chk({hs, fault_n}, 5'h00);
        inj.vpwr_ov = 1'b0;
        inj.wake_reset_input = 1'b0;
        fs = 1'b0;
        w(4);
        chk({hs, sense, st.temp_prewarning_flag}, 11'h7df);
        inj.temp_warn = 1'b0;
        // warning must have left the sync stages, else the set beats the read
        w(4);
        rd_st();
        chk(st, 27'h0);
        cmd = 4'h0;
        w(4);
        inj.vpwr_uv = 1'b1;
        w(4);
        chk({hs, fault_n, st.undervoltage_flag}, 6'h01);
        inj.vpwr_uv = 1'b0;
        w(4);
        chk({fault_n, st.undervoltage_flag}, 2'b11);
        rd_st();
        chk(st.undervoltage_flag, 1'b0);
        cmd = 4'hf;
        w(4);
        inj.vpwr_uv = 1'b1;
        w(4);
        inj.vpwr_uv = 1'b0;
        w(6);
        chk({hs, fault_n}, 5'h00);
        // delatch needs the command to drop and rise again
        cmd = 4'h0;
        w(2);
        cmd = 4'hf;
        w(4);
        chk({hs, fault_n}, 5'h1f);
        rd_st();
        short0();
        chk({hs, fault_n, st.severe_short_flag}, 9'h1c1);
        inj.vdd_fail = 1'b1;
        w(4);
        inj.vdd_fail = 1'b0;
        w(4);
        chk({hs, st.severe_short_flag}, 8'hf0);
        short0();
        rd_st();
        chk({hs, st.severe_short_flag}, 8'he0);
        // toggle output 0 so its severe short latch lets the pin go
        cmd = 4'hc;
        w(2);
        cmd = 4'hd;
        w(4);
        inj.short_to_supply[1] = 1'b1;
        w(4);
        chk({fault_n, st.short_to_supply_flag, st.open_load_off_flag}, 9'h022);
        inj.short_to_supply[1] = 1'b0;
        w(4);
        chk({fault_n, st.short_to_supply_flag, st.open_load_off_flag}, 9'h122);
        rd_st();
        chk({st.short_to_supply_flag, st.open_load_off_flag}, 8'h00);
        short_to_supply_disable = 4'h2;
        inj.short_to_supply[1] = 1'b1;
        w(4);
        chk(st.short_to_supply_flag, 4'h0);
        inj.short_to_supply[1] = 1'b0;
        short_to_supply_disable = 4'h0;
        w(4);
        rd_st();
        inj.open_load_off[1] = 1'b1;
        w(4);
        chk({fault_n, st.open_load_off_flag}, 5'h02);
        inj.open_load_off[1] = 1'b0;
        w(4);
        rd_st();
        chk({fault_n, st.open_load_off_flag}, 5'h10);
        open_load_off_disable = 4'h2;
        inj.open_load_off[1] = 1'b1;
        w(4);
        chk({fault_n, st.open_load_off_flag}, 5'h10);
        inj.open_load_off[1] = 1'b0;
        open_load_off_disable = 4'h0;
        inj.open_load_on[2] = 1'b1;
        w(4);
        chk({hs, fault_n, st.open_load_on_flag}, 9'h1b4);
        rd_st();
        chk(st.open_load_on_flag, 4'h4);
        inj.open_load_on[2] = 1'b0;
        w(4);
        rd_st();
        chk(st.open_load_on_flag, 4'h0);
        open_load_on_disable = 4'h4;
        inj.open_load_on[2] = 1'b1;
        w(4);
        chk(st.open_load_on_flag, 4'h0);
        // restart output 2 so the full-duty check period starts afresh
        open_load_on_disable = 4'h0;
        cmd = 4'h9;
        led_sel = 4'h4;
        duty[2] = 7'h7f;
        w(4);
        cmd = 4'hd;
        w(900);
        chk(st.open_load_on_flag, 4'h0);
        w(200);
        chk(st.open_load_on_flag, 4'h4);
        inj.open_load_on[2] = 1'b0;
        cmd = 4'hf;
        retry_en = 1'b1;
        w(4);
        rd_st();
        for (int i = 0; i < 16; i++)
            oc_retry(1'b1);
        oc_retry(1'b0);
        fs = 1'b1;
        w(4);
        fs = 1'b0;
        w(4);
        oc_retry(1'b1);
        test_done();
    end
endmodule // tb_quad_switch_fault_diag_manager
